// ==== common/uart_bus_pkg.sv ====
// shared constants and types for the uart host bus ends
`default_nettype none
package uart_bus_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_PULSE_NS = 40;
  // pulse must be strictly longer than the minimum
  localparam int RESET_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS + 1;
  localparam int STROBE_CYCLES = 6;
  localparam int FIFO_DEPTH = 64;
  // device register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_FIFO = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SPR = 3'h7;
  // enhanced bank: line control value that opens it
  localparam logic [7:0] ENHANCED_KEY = 8'h_BF;
  localparam logic [2:0] OFS_XON = 3'h4;
  localparam logic [2:0] OFS_XOFF = 3'h5;
  localparam logic [2:0] OFS_TRIG = 3'h6;
  localparam logic [2:0] OFS_TXFILL = 3'h7;
  // fields
  localparam int FIFO_EN_BIT = 0;
  localparam int RXCLR_BIT = 1;
  localparam int TXCLR_BIT = 2;
  localparam int DLAB_BIT = 7;
  localparam int SWFLOW_BIT = 3;
  localparam int IER_RX_BIT = 0;
  localparam int IER_TX_BIT = 1;
  // reset values
  localparam logic [7:0] DIV_LOW_RESET = 8'h_01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h_00;
  localparam logic [7:0] TRIG_RESET = 8'h_20;
  localparam logic [7:0] XON_RESET = 8'h_11;
  localparam logic [7:0] XOFF_RESET = 8'h_13;
  // identity codes, values arbitrary
  localparam logic [7:0] DEVICE_ID = 8'h_5A;
  localparam logic [7:0] REVISION_ID = 8'h_3C;
  // host controller register offsets
  localparam logic [2:0] H_CTRL = 3'h0;
  localparam logic [2:0] H_XFER = 3'h1;
  localparam logic [2:0] H_RESULT = 3'h2;
  localparam logic [2:0] H_STATUS = 3'h3;
  localparam logic [2:0] H_EVENTS = 3'h4;
  localparam logic [2:0] H_MASK = 3'h5;
  localparam logic [1:0] EV_DONE = 2'h1;
  localparam logic [1:0] EV_DEVINT = 2'h2;
  localparam int XFER_READ_BIT = 11;
  typedef enum logic [2:0] {HIdle, HSetup, HStrobe, HHold, HReset} host_state_t;
endpackage : uart_bus_pkg
`default_nettype wire

// ==== common/uart_bus_if.sv ====
// pin bundle between host processor and uart device
`default_nettype none
interface uart_bus_if;
  logic chipSelectN;
  logic read_strobe_n;
  logic write_strobe_n;
  logic readWriteN;
  logic [2:0] regAddr;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic busStyle;
  logic hwReset;
  logic intPin;
  logic bus_isolate_input;
  modport host (output chipSelectN, read_strobe_n, write_strobe_n, readWriteN, regAddr, hostData,
    hostDataOe, busStyle, hwReset, bus_isolate_input, input devData, devDataOe, intPin);
  modport device (input chipSelectN, read_strobe_n, write_strobe_n, readWriteN, regAddr, hostData,
    hostDataOe, busStyle, hwReset, bus_isolate_input, output devData, devDataOe, intPin);
endinterface : uart_bus_if
`default_nettype wire

// ==== core/uart_device_end.sv ====
// uart device: async host bus slave, fifos, serial line, interrupt pin
//
// The register addresses and the strobed register port were chosen for this implementation.
`default_nettype none
module uart_device_end
  import uart_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  uart_bus_if.device bus,
  input wire logic rxSerial,
  input wire logic duplexSelect,
  input wire logic osc_input,
  output logic txSerial,
  output logic driverEnable,
  output logic halfDuplex,
  output logic osc_buffered_output
);
  typedef struct packed {
    logic [7:0] ier, lcr, mcr, spr, fifoCtrl, divLow, divHigh, featEnable, xon, xoff, trig;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{8'h_00, 8'h_00, 8'h_00, 8'h_00, 8'h_00, DIV_LOW_RESET,
    DIV_HIGH_RESET, 8'h_00, XON_RESET, XOFF_RESET, TRIG_RESET};
  localparam int NSYNC = 20;

  // two-stage synchronisers for every pin from the host except hostDataOe, and for the line and the oscillator input
  logic [NSYNC-1:0] syncA, syncB, raw;
  assign raw = {bus.bus_isolate_input, bus.busStyle, bus.hwReset, bus.chipSelectN, bus.read_strobe_n,
    bus.write_strobe_n, bus.readWriteN, bus.regAddr, bus.hostData, rxSerial, osc_input};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        syncA[gi] <= raw[gi];
        syncB[gi] <= syncA[gi];
      end
    end
  endgenerate
  logic isolate, styleSep, rstPin, csN, rdN, wrN, rwN, rxIn, oscIn;
  logic [2:0] addrIn;
  logic [7:0] dataIn;
  assign {isolate, styleSep, rstPin, csN, rdN, wrN, rwN, addrIn, dataIn, rxIn, oscIn} = syncB;

  // reset pin polarity follows the bus style
  logic rst;
  assign rst = !resetn || (styleSep ? rstPin : !rstPin);
  // access requests from strobes alone, no baud clock involved
  logic reqRd, reqWr;
  assign reqRd = !isolate && !csN && (styleSep ? !rdN : rwN);
  assign reqWr = !isolate && !csN && (styleSep ? !wrN : !rwN);

  // state
  cfg_t cfg, next_cfg;
  logic prevRd, prevWr, next_prevRd, next_prevWr, driveOut, next_driveOut, dupLatched, next_dupLatched;
  logic half, next_half, txPaused, next_txPaused, intOut, next_intOut, txOut, next_txOut;
  logic [2:0] wrAddr, next_wrAddr;
  logic [7:0] wrData, next_wrData, readValue, next_readValue;
  logic [7:0] txMem [FIFO_DEPTH];
  logic [7:0] rxMem [FIFO_DEPTH];
  logic [5:0] txWp, txRp, rxWp, rxRp, next_txWp, next_txRp, next_rxWp, next_rxRp;
  logic [6:0] txCnt, rxCnt, next_txCnt, next_rxCnt;
  logic [15:0] baudCnt, next_baudCnt;
  logic [3:0] txTick, rxTick, txBits, rxBits, next_txTick, next_rxTick, next_txBits, next_rxBits;
  logic [9:0] txShift, next_txShift;
  logic [7:0] rxShift, next_rxShift;
  logic txBusy, rxBusy, next_txBusy, next_rxBusy, oscOut, next_oscOut;

  // decode helpers
  logic rdStart, wrEnd, enh, dlab, fifoEn, baudTick, txPush, txPop, rxPush, rxPop, idMode;
  logic [6:0] limit, trig7;
  logic [7:0] isr;
  assign rdStart = reqRd && !prevRd;
  assign wrEnd = prevWr && !reqWr;
  assign enh = cfg.lcr == ENHANCED_KEY;
  assign dlab = cfg.lcr[DLAB_BIT];
  assign fifoEn = cfg.fifoCtrl[FIFO_EN_BIT];
  assign limit = fifoEn ? 7'(FIFO_DEPTH) : 7'd1;
  assign trig7 = cfg.trig[6:0];
  assign idMode = cfg.divLow == 8'h_00 && cfg.divHigh == 8'h_00;
  assign baudTick = baudCnt == 16'h_0000;
  assign txPush = wrEnd && wrAddr == OFS_DATA && !dlab && !enh && txCnt < limit;
  assign rxPop = rdStart && addrIn == OFS_DATA && !dlab && !enh && rxCnt != 7'd0;
  assign txPop = !txBusy && txCnt != 7'd0 && !txPaused && baudTick;

  // transmit and receive interrupt levels
  logic txInt, rxInt;
  always_comb begin
    txInt = fifoEn ? (txCnt < trig7 || txCnt == 7'd0) : txCnt == 7'd0;
    rxInt = fifoEn ? rxCnt > trig7 : rxCnt != 7'd0;
    isr = {fifoEn, fifoEn, 6'h_01};
    if (rxInt && cfg.ier[IER_RX_BIT]) begin
      isr[3:0] = 4'h_4;
    end else if (txInt && cfg.ier[IER_TX_BIT]) begin
      isr[3:0] = 4'h_2;
    end
  end

  // host bus: register writes on strobe release, read data on strobe start
  always_comb begin
    next_cfg = cfg;
    next_prevRd = reqRd;
    next_prevWr = reqWr;
    next_wrAddr = reqWr ? addrIn : wrAddr;
    next_wrData = reqWr ? dataIn : wrData;
    next_driveOut = reqRd;
    next_readValue = readValue;
    // pin level already carries the style polarity
    next_intOut = styleSep ? ((rxInt && cfg.ier[IER_RX_BIT]) || (txInt && cfg.ier[IER_TX_BIT])) :
      !((rxInt && cfg.ier[IER_RX_BIT]) || (txInt && cfg.ier[IER_TX_BIT]));
    if (wrEnd) begin
      unique case (wrAddr)
        OFS_DATA: if (dlab) next_cfg.divLow = wrData;
        OFS_IER: if (dlab) next_cfg.divHigh = wrData; else next_cfg.ier = wrData;
        OFS_FIFO: if (enh) next_cfg.featEnable = wrData; else next_cfg.fifoCtrl = wrData;
        OFS_LCR: next_cfg.lcr = wrData;
        OFS_MCR: if (enh) next_cfg.xon = wrData; else next_cfg.mcr = wrData;
        OFS_LSR: if (enh) next_cfg.xoff = wrData;
        OFS_MSR: if (enh) next_cfg.trig = wrData;
        OFS_SPR: if (!enh) next_cfg.spr = wrData;
      endcase
    end
    if (rdStart) begin
      unique case (addrIn)
        OFS_DATA: next_readValue = dlab ? (idMode ? REVISION_ID : cfg.divLow) : rxMem[rxRp];
        OFS_IER: next_readValue = dlab ? (idMode ? DEVICE_ID : cfg.divHigh) : cfg.ier;
        OFS_FIFO: next_readValue = enh ? cfg.featEnable : isr;
        OFS_LCR: next_readValue = cfg.lcr;
        OFS_MCR: next_readValue = enh ? cfg.xon : cfg.mcr;
        OFS_LSR: next_readValue = enh ? cfg.xoff : {1'b0, txCnt == 7'd0 && !txBusy, txCnt == 7'd0, 4'h_0,
          rxCnt != 7'd0};
        OFS_MSR: next_readValue = enh ? {1'b0, rxCnt} : 8'h_00;
        OFS_SPR: next_readValue = enh ? {1'b0, txCnt} : cfg.spr;
      endcase
    end
  end

  // baud generator on the reference clock, 16 ticks a bit, 8N1 framing
  always_comb begin
    next_baudCnt = baudTick ? (idMode ? 16'h_FFFF : {cfg.divHigh, cfg.divLow} - 16'h_0001) :
      baudCnt - 16'h_0001;
    next_txTick = txTick;
    next_txBits = txBits;
    next_txShift = txShift;
    next_txBusy = txBusy;
    next_txOut = txOut;
    next_rxTick = rxTick;
    next_rxBits = rxBits;
    next_rxShift = rxShift;
    next_rxBusy = rxBusy;
    next_txPaused = txPaused;
    rxPush = 1'b0;
    if (txPop) begin
      next_txShift = {1'b1, txMem[txRp], 1'b0};
      next_txBusy = 1'b1;
      next_txTick = 4'h_0;
      next_txBits = 4'h_0;
    end else if (txBusy && baudTick) begin
      next_txTick = txTick + 4'h_1;
      if (txTick == 4'h_0) begin
        next_txOut = txShift[0];
        next_txShift = {1'b1, txShift[9:1]};
        next_txBits = txBits + 4'h_1;
      end
      if (txTick == 4'h_F && txBits == 4'd10) begin
        next_txBusy = 1'b0;
      end
    end
    if (baudTick) begin
      if (!rxBusy) begin
        if (!rxIn) begin
          next_rxBusy = 1'b1;
          next_rxTick = 4'h_1;
          next_rxBits = 4'h_0;
        end
      end else begin
        next_rxTick = rxTick + 4'h_1;
        if (rxTick == 4'h_7) begin
          next_rxBits = rxBits + 4'h_1;
          if (rxBits == 4'h_0 && rxIn) begin
            next_rxBusy = 1'b0; // false start
          end else if (rxBits == 4'd9) begin
            next_rxBusy = 1'b0;
            rxPush = rxIn && rxCnt < limit;
            if (cfg.featEnable[SWFLOW_BIT] && rxIn && rxShift == cfg.xoff) begin
              next_txPaused = 1'b1;
            end else if (cfg.featEnable[SWFLOW_BIT] && rxIn && rxShift == cfg.xon) begin
              next_txPaused = 1'b0;
            end
          end else begin
            next_rxShift = {rxIn, rxShift[7:1]};
          end
        end
      end
    end
    if (!cfg.featEnable[SWFLOW_BIT]) begin
      next_txPaused = 1'b0;
    end
  end

  // fifo pointers and counts
  always_comb begin
    next_txWp = txPush ? txWp + 6'd1 : txWp;
    next_txRp = txPop ? txRp + 6'd1 : txRp;
    next_txCnt = txCnt + 7'(txPush) - 7'(txPop);
    next_rxWp = rxPush ? rxWp + 6'd1 : rxWp;
    next_rxRp = rxPop ? rxRp + 6'd1 : rxRp;
    next_rxCnt = rxCnt + 7'(rxPush) - 7'(rxPop);
    if (wrEnd && wrAddr == OFS_FIFO && !enh) begin
      if (wrData[TXCLR_BIT]) begin
        next_txWp = 6'd0;
        next_txRp = 6'd0;
        next_txCnt = 7'd0;
      end
      if (wrData[RXCLR_BIT]) begin
        next_rxWp = 6'd0;
        next_rxRp = 6'd0;
        next_rxCnt = 7'd0;
      end
    end
    next_dupLatched = 1'b1;
    next_half = dupLatched ? half : duplexSelect;
    next_oscOut = oscIn;
  end

  // fifo storage
  always_ff @(posedge ref_clk) begin
    if (txPush) begin
      txMem[txWp] <= wrData;
    end
    if (rxPush) begin
      rxMem[rxWp] <= rxShift;
    end
  end

  // registers; duplex latch survives the host reset pin, only power-up clears it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dupLatched <= 1'b0;
      half <= 1'b0;
    end else begin
      dupLatched <= next_dupLatched;
      half <= next_half;
    end
    oscOut <= rst ? 1'b0 : next_oscOut;
    if (rst) begin
      cfg <= CFG_RESET;
      {prevRd, prevWr, driveOut, txPaused, txBusy, rxBusy} <= 6'h_00;
      intOut <= !styleSep; // inactive level of the current style
      txOut <= 1'b1;
      wrAddr <= 3'h0;
      wrData <= 8'h_00;
      readValue <= 8'h_00;
      {txWp, txRp, rxWp, rxRp} <= 24'h_00_0000;
      {txCnt, rxCnt} <= 14'h_0000;
      baudCnt <= 16'h_0000;
      {txTick, rxTick, txBits, rxBits} <= 16'h_0000;
      txShift <= 10'h_3FF;
      rxShift <= 8'h_00;
    end else begin
      cfg <= next_cfg;
      {prevRd, prevWr, driveOut, txPaused, intOut} <= {next_prevRd, next_prevWr, next_driveOut,
        next_txPaused, next_intOut};
      {txBusy, rxBusy, txOut} <= {next_txBusy, next_rxBusy, next_txOut};
      {wrAddr, wrData, readValue} <= {next_wrAddr, next_wrData, next_readValue};
      {txWp, txRp, rxWp, rxRp} <= {next_txWp, next_txRp, next_rxWp, next_rxRp};
      {txCnt, rxCnt, baudCnt} <= {next_txCnt, next_rxCnt, next_baudCnt};
      {txTick, rxTick, txBits, rxBits} <= {next_txTick, next_rxTick, next_txBits, next_rxBits};
      {txShift, rxShift} <= {next_txShift, next_rxShift};
    end
  end

  // pins: interrupt straight from its flop, line driver by duplex mode
  assign bus.intPin = intOut;
  assign bus.devData = readValue;
  assign bus.devDataOe = driveOut;
  assign txSerial = txOut;
  assign driverEnable = half ? txBusy : 1'b1;
  assign halfDuplex = half;
  assign osc_buffered_output = oscOut;
endmodule : uart_device_end
`default_nettype wire

// ==== core/uart_host_end.sv ====
// host processor end: drives async bus cycles from a register port
`default_nettype none
module uart_host_end
  import uart_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  uart_bus_if.host bus,
  input wire logic [2:0] userAddr,
  input wire logic [15:0] userWdata,
  input wire logic userWr,
  input wire logic userRd,
  output logic [15:0] userRdata,
  output logic irq
);
  host_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic style, next_style, iso, next_iso, isRead, next_isRead, lastInt, next_lastInt, next_irq;
  logic [2:0] addr, next_addr;
  logic [7:0] data, next_data, result, next_result;
  logic [1:0] events, next_events, mask, next_mask;
  logic [15:0] next_rdata;
  logic csN, rdN, wrN, rwN, oe, rstAct, next_csN, next_rdN, next_wrN, next_rwN, next_oe, next_rstAct;
  logic devInt, done;
  assign devInt = style ? bus.intPin : !bus.intPin;

  // sequencer and pin levels per style
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_style = style;
    next_iso = iso;
    next_isRead = isRead;
    next_addr = addr;
    next_data = data;
    next_result = result;
    next_mask = mask;
    next_lastInt = devInt;
    done = 1'b0;
    if (userWr && userAddr == H_CTRL) begin
      next_style = userWdata[0];
      next_iso = userWdata[1];
    end
    if (userWr && userAddr == H_MASK) begin
      next_mask = userWdata[1:0];
    end
    unique case (state)
      HIdle: begin
        if (userWr && userAddr == H_CTRL && userWdata[2]) begin
          next_state = HReset;
          next_cnt = 4'(RESET_CYCLES - 1);
        end else if (userWr && userAddr == H_XFER) begin
          next_state = HSetup;
          next_isRead = userWdata[XFER_READ_BIT];
          next_addr = userWdata[10:8];
          next_data = userWdata[7:0];
        end
      end
      HSetup: begin
        next_state = HStrobe;
        next_cnt = 4'(STROBE_CYCLES - 1);
      end
      HStrobe: begin
        next_cnt = cnt - 4'h_1;
        if (cnt == 4'h_0) begin
          next_state = HHold;
          if (isRead) begin
            next_result = bus.devData;
          end
        end
      end
      HHold: begin
        next_state = HIdle;
        done = 1'b1;
      end
      HReset: begin
        next_cnt = cnt - 4'h_1;
        if (cnt == 4'h_0) begin
          next_state = HIdle;
        end
      end
    endcase
    // separate style: cs spans setup..hold, strobe in the middle; direction style: cs is the strobe
    next_csN = !(next_state == HStrobe || (next_style && (next_state == HSetup || next_state == HHold)));
    next_rdN = !(next_style && next_state == HStrobe && next_isRead);
    next_wrN = !(next_style && next_state == HStrobe && !next_isRead);
    next_rwN = next_style ? 1'b1 : (next_state == HIdle || next_state == HReset ? 1'b1 : next_isRead);
    next_oe = !next_isRead && (next_state == HSetup || next_state == HStrobe || next_state == HHold);
    next_rstAct = next_style ? next_state == HReset : next_state != HReset;
    next_events = events;
    if (userRd && userAddr == H_EVENTS) begin
      next_events = 2'h0;
    end
    if (done) begin
      next_events = next_events | EV_DONE; // set wins over read clear
    end
    if (devInt && !lastInt) begin
      next_events = next_events | EV_DEVINT;
    end
    next_irq = |(next_events & next_mask);
    unique case (userAddr)
      H_CTRL: next_rdata = {14'h_0000, iso, style};
      H_RESULT: next_rdata = {8'h_00, result};
      H_STATUS: next_rdata = {14'h_0000, devInt, state != HIdle};
      H_EVENTS: next_rdata = {14'h_0000, events};
      H_MASK: next_rdata = {14'h_0000, mask};
      default: next_rdata = 16'h_0000;
    endcase
    if (!userRd) begin
      next_rdata = 16'h_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= HIdle;
      cnt <= 4'h_0;
      {style, iso, isRead, lastInt, irq} <= 5'h_10;
      {addr, data, result} <= 19'h_0_0000;
      {events, mask} <= 4'h_0;
      userRdata <= 16'h_0000;
      {csN, rdN, wrN, rwN, oe, rstAct} <= 6'h_3C;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      {style, iso, isRead, lastInt, irq} <= {next_style, next_iso, next_isRead, next_lastInt, next_irq};
      {addr, data, result} <= {next_addr, next_data, next_result};
      {events, mask} <= {next_events, next_mask};
      userRdata <= next_rdata;
      {csN, rdN, wrN, rwN, oe, rstAct} <= {next_csN, next_rdN, next_wrN, next_rwN, next_oe, next_rstAct};
    end
  end

  assign bus.chipSelectN = csN;
  assign bus.read_strobe_n = rdN;
  assign bus.write_strobe_n = wrN;
  assign bus.readWriteN = rwN;
  assign bus.regAddr = addr;
  assign bus.hostData = data;
  assign bus.hostDataOe = oe;
  assign bus.busStyle = style;
  assign bus.hwReset = rstAct;
  assign bus.bus_isolate_input = iso;
endmodule : uart_host_end
`default_nettype wire

// ==== test/uart_host_bus_and_interrupt_asserts.sv ====
// pin-level checker for the host bus between the two ends
`default_nettype none
module uart_host_bus_and_interrupt_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic readWriteN,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic busStyle,
  input wire logic hwReset,
  input wire logic intPin,
  input wire logic bus_isolate_input
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // data lines, turnaround and isolation
  AST_ONE_DRIVER: assert property (!(hostDataOe && devDataOe)) else $error("both ends drive data");
  AST_ISOLATED: assert property (bus_isolate_input [*4] |-> !devDataOe) else $error("isolated bus driven");
  AST_RD_STYLE1: assert property ($fell(read_strobe_n) && busStyle && !chipSelectN && !bus_isolate_input
    |-> ##3 devDataOe) else $error("no read answer in strobe style");
  AST_RD_STYLE0: assert property ($fell(chipSelectN) && !busStyle && readWriteN && !bus_isolate_input
    |-> ##3 devDataOe) else $error("no read answer in direction style");
  AST_RD_RELEASE: assert property ($rose(chipSelectN) |-> ##[1:4] !devDataOe) else $error("data held too long");
  AST_WR_QUIET: assert property (busStyle && !write_strobe_n |-> !devDataOe) else $error("drive during write");
  // interrupt pin goes to the idle level of its style (low separate, high direction) after a reset pulse
  AST_INT_RST1: assert property ((busStyle && hwReset) [*2] |-> ##5 !intPin) else $error("int pin not idle low");
  AST_INT_RST0: assert property ((!busStyle && !hwReset) [*2] |-> ##5 intPin) else $error("int pin not idle high");
  // main scenarios
  COV_RD1: cover property ($fell(read_strobe_n) && busStyle ##3 devDataOe);
  COV_RD0: cover property ($fell(chipSelectN) && !busStyle && readWriteN ##3 devDataOe);
  COV_ISO: cover property (bus_isolate_input && !chipSelectN);
endmodule : uart_host_bus_and_interrupt_asserts
`default_nettype wire

// ==== test/uart_host_bus_and_interrupt_tb_top.sv ====
// self-checking bench joining the host end and the device end
`default_nettype none
module uart_host_bus_and_interrupt_tb_top
  import uart_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] userAddr = 3'h0;
  logic [15:0] userWdata = 16'h_0000;
  logic userWr = 1'b0;
  logic userRd = 1'b0;
  logic oscIn = 1'b0;
  logic duplexStrap = 1'b0;
  logic [15:0] userRdata;
  logic [15:0] rv;
  logic irq;
  logic txSerial;
  logic driverEnable;
  logic halfDuplex;
  logic oscOut;
  int err_total = 0;
  int checked = 0;
  uart_bus_if bus ();
  always #12.5 ref_clk = ~ref_clk;
  // serial line looped back, full duplex strap
  uart_host_end uart_host_end_i (.ref_clk(ref_clk), .resetn(resetn), .bus(bus.host), .userAddr(userAddr),
    .userWdata(userWdata), .userWr(userWr), .userRd(userRd), .userRdata(userRdata), .irq(irq));
  uart_device_end uart_device_end_i (.ref_clk(ref_clk), .resetn(resetn), .bus(bus.device), .rxSerial(txSerial),
    .duplexSelect(duplexStrap), .osc_input(oscIn), .txSerial(txSerial), .driverEnable(driverEnable),
    .halfDuplex(halfDuplex), .osc_buffered_output(oscOut));
  uart_host_bus_and_interrupt_asserts uart_host_bus_and_interrupt_asserts_i (.ref_clk(ref_clk), .resetn(resetn),
    .chipSelectN(bus.chipSelectN), .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .readWriteN(bus.readWriteN), .hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe), .busStyle(bus.busStyle),
    .hwReset(bus.hwReset), .intPin(bus.intPin), .bus_isolate_input(bus.bus_isolate_input));
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // one-cycle strobes on the user register port
  task automatic uwr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    userAddr <= a;
    userWdata <= d;
    userWr <= 1'b1;
    @(posedge ref_clk);
    userWr <= 1'b0;
  endtask : uwr
  task automatic urd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    userAddr <= a;
    userRd <= 1'b1;
    @(posedge ref_clk);
    userRd <= 1'b0;
    #1;
    d = userRdata;
  endtask : urd
  // one device access, polled until the host end is idle
  task automatic xfer(input logic rd, input logic [2:0] r, input logic [7:0] d);
    logic [15:0] s;
    uwr(H_XFER, {4'h0, rd, r, d});
    s = 16'h_0001;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++) begin
      urd(H_STATUS, s);
    end
    check("busy", 16'(s[0]), 16'h_0000);
    if (rd) begin
      urd(H_RESULT, rv);
    end
  endtask : xfer
  task automatic t_int();
    uwr(H_MASK, 16'h_0002);
    xfer(1'b0, OFS_IER, 8'h_02);
    repeat (4) @(posedge ref_clk);
    check("tx int", 16'(bus.intPin), 16'h_0001);
    check("irq", 16'(irq), 16'h_0001);
    urd(H_EVENTS, rv);
    check("event", rv & 16'h_0002, 16'h_0002);
    urd(H_EVENTS, rv);
    check("event clr", rv & 16'h_0002, 16'h_0000);
    check("irq clr", 16'(irq), 16'h_0000);
    xfer(1'b0, OFS_IER, 8'h_01);
    xfer(1'b0, OFS_DATA, 8'h_A5);
    check("rx none", 16'(bus.intPin), 16'h_0000);
    repeat (220) @(posedge ref_clk);
    check("rx int", 16'(bus.intPin), 16'h_0001);
    xfer(1'b1, OFS_DATA, 8'h_00);
    check("rx data", rv, 16'h_00A5);
    check("rx off", 16'(bus.intPin), 16'h_0000);
    // direction-line style inverts the pin
    uwr(H_CTRL, 16'h_0000);
    repeat (6) @(posedge ref_clk);
    check("low idle", 16'(bus.intPin), 16'h_0001);
    xfer(1'b0, OFS_SPR, 8'h_3C);
    xfer(1'b1, OFS_SPR, 8'h_00);
    check("rw spr", rv, 16'h_003C);
    xfer(1'b0, OFS_IER, 8'h_02);
    repeat (4) @(posedge ref_clk);
    check("low tx", 16'(bus.intPin), 16'h_0000);
    uwr(H_CTRL, 16'h_0004);
    repeat (10) @(posedge ref_clk);
    check("rst low", 16'(bus.intPin), 16'h_0001);
    uwr(H_CTRL, 16'h_0001);
  endtask : t_int
  task automatic t_reset_id();
    xfer(1'b0, OFS_IER, 8'h_02);
    uwr(H_CTRL, 16'h_0005);
    repeat (10) @(posedge ref_clk);
    check("rst int", 16'(bus.intPin), 16'h_0000);
    xfer(1'b0, OFS_LCR, 8'h_80);
    xfer(1'b1, OFS_DATA, 8'h_00);
    check("div low", rv, {8'h_00, DIV_LOW_RESET});
    xfer(1'b0, OFS_DATA, 8'h_00);
    xfer(1'b0, OFS_IER, 8'h_00);
    xfer(1'b1, OFS_IER, 8'h_00);
    check("id", rv, {8'h_00, DEVICE_ID});
    xfer(1'b1, OFS_DATA, 8'h_00);
    check("rev", rv, {8'h_00, REVISION_ID});
    xfer(1'b0, OFS_DATA, 8'h_01);
    xfer(1'b0, OFS_LCR, 8'h_03);
  endtask : t_reset_id
  task automatic t_isolate();
    xfer(1'b0, OFS_SPR, 8'h_11);
    uwr(H_CTRL, 16'h_0003);
    xfer(1'b0, OFS_SPR, 8'h_22);
    xfer(1'b1, OFS_SPR, 8'h_00);
    uwr(H_CTRL, 16'h_0001);
    xfer(1'b1, OFS_SPR, 8'h_00);
    check("isolate", rv, 16'h_0011);
  endtask : t_isolate
  task automatic t_misc();
    check("half", 16'(halfDuplex), 16'h_0000);
    check("drv en", 16'(driverEnable), 16'h_0001);
    @(posedge ref_clk);
    oscIn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("osc", 16'(oscOut), 16'h_0001);
    // second power-up with the half-duplex strap; later strap changes are ignored
    resetn <= 1'b0;
    duplexStrap <= 1'b1;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    duplexStrap <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("half set", 16'(halfDuplex), 16'h_0001);
    check("drv idle", 16'(driverEnable), 16'h_0000);
  endtask : t_misc
  // slow divisor keeps the transmit fifo from draining
  task automatic t_fifo();
    xfer(1'b0, OFS_LCR, 8'h_80);
    xfer(1'b0, OFS_IER, 8'h_01);
    xfer(1'b0, OFS_LCR, 8'h_03);
    xfer(1'b0, OFS_FIFO, 8'h_07);
    xfer(1'b0, OFS_IER, 8'h_02);
    repeat (4) @(posedge ref_clk);
    check("fifo empty", 16'(bus.intPin), 16'h_0001);
    for (int i = 0; i < 70; i++) begin
      xfer(1'b0, OFS_DATA, 8'(i));
    end
    check("fifo above", 16'(bus.intPin), 16'h_0000);
    xfer(1'b0, OFS_LCR, ENHANCED_KEY);
    xfer(1'b1, OFS_TXFILL, 8'h_00);
    check("tx fill", rv, 16'(FIFO_DEPTH));
  endtask : t_fifo
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_int();
    t_reset_id();
    t_isolate();
    t_misc();
    t_fifo();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
endmodule : uart_host_bus_and_interrupt_tb_top
`default_nettype wire
